// [design/dpr_regs.vh]
// Constants for the DDR bus slave read/write path: command word fields,
// phase lengths, latency multipliers and transaction states.
// Assumes inclusion by bare name from the design files only.
`ifndef DPR_REGS_VH
`define DPR_REGS_VH

// Command-address word field positions
`define DPR_CA_WIDTH 48
`define DPR_CA_READ_BIT 47
`define DPR_CA_SPACE_BIT 46
`define DPR_CA_BURST_BIT 45
`define DPR_CA_ROW_MSB 44
`define DPR_CA_ROW_LSB 16
`define DPR_CA_COL_MSB 2
`define DPR_CA_COL_LSB 0

// Bus edges spent in the command-address phase (3 clocks, 2 edges each)
`define DPR_CA_EDGES 3'h6
// Edge index after which bits 47..16 are complete
`define DPR_ROW_LAST_EDGE 3'h3
// Edge index of the last command-address edge
`define DPR_CA_LAST_EDGE 3'h5

// Shift from latency clocks to bus edges: two per clock, four when doubled
`define DPR_LAT_EDGES_STD 2'h1
`define DPR_LAT_EDGES_EXT 2'h2

// Transaction states
`define DPR_ST_IDLE 3'h0
`define DPR_ST_CA 3'h1
`define DPR_ST_LAT 3'h2
`define DPR_ST_RDATA 3'h3
`define DPR_ST_WDATA 3'h4

// Synchroniser reset levels: chip select idle high, clock idle low
`define DPR_SYNC_INIT 11'h400

`endif

// [design/dpr_sync.v]
// Two-flop synchroniser for a group of asynchronous bus pins.
// Assumes the pins are stable relative to each other for several clock periods.
`timescale 1ns/1ns

module dpr_sync #(
	parameter W = 11,
	parameter [W-1:0] INIT = {W{1'b0}}
) (
	input wire i_ref_clk,    // Sampling clock
	input wire i_reset_n,    // Asynchronous reset, active low
	input wire [W-1:0] i_d,  // Asynchronous pins
	output reg [W-1:0] o_q   // Synchronised copy
);

	reg [W-1:0] meta;

	// --------------------------------------------------------------
	// Two stages; only the second stage is read outside
	// --------------------------------------------------------------
	always @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meta <= INIT;
			o_q <= INIT;
		end else begin
			meta <= i_d;
			o_q <= meta;
		end
	end

endmodule

// [design/dpr_slave.v]
// Functional notes
// - Register reads put word bits 15:8 after strobe rise, 7:0 after fall.
// - Register writes take upper byte on clock rise, lower byte on fall.
// - Writes with latency use strobe as per-byte mask in data phase.
// - Zero-latency writes: host leaves strobe alone, every byte is written.
// - Zero-latency write data phase: device strobe low or released.
// - Command bit 47 read, bit 46 register space, bit 45 burst type.
// - Array access starts after bits 47..16; bits 2..0 pick the word.
// - Strobe during command phase: low one latency, high two.
// - Latency count per step comes from the configuration setting.
// - After latency, strobe toggles with data edge-aligned to it.
// - Burst data continues while host clocks with select low.
// - Wrapped bursts wrap in burst length; linear bursts run on.
// - Linear read past last address continues from address zero.
// - Host may raise select with clock idle; device ends transfer.
// - No free-running clock needed; clock may stop with select high.
// - Device drives the strobe throughout reads.
// - Register space always uses big-endian byte order.
// - Masked write: strobe high keeps byte, strobe low writes it.
//
// DDR bus slave: command decode, latency, read strobe/data, write capture.
// Assumes the bus clock half period spans at least four reference clocks,
// and i_mem_rdata is valid the cycle after an o_mem_rd pulse.
`timescale 1ns/1ns
`include "dpr_regs.vh"

module dpr_slave #(
	parameter ADDR_W = 23,
	parameter LAT_W = 4
) (
	input wire i_ref_clk,                // Reference clock, 20 MHz
	input wire i_reset_n,                // Asynchronous reset, active low
	input wire i_cs_n,                   // Bus chip select, active low
	input wire i_ck,                     // Bus clock from host
	input wire [7:0] i_dq,               // Bus data in
	input wire i_rw_data_strobe,         // Strobe in (write mask)
	input wire [LAT_W-1:0] i_latency,    // Clocks per latency count
	input wire i_refresh_busy,           // Request doubled latency
	input wire [ADDR_W-1:0] i_wrap_mask, // Low address bits that wrap
	input wire [15:0] i_mem_rdata,       // Word read back from store
	output reg [7:0] o_dq,               // Bus data out
	output reg o_dq_oe,                  // Bus data output enable
	output reg o_rw_data_strobe,         // Strobe out
	output reg o_rw_data_strobe_oe,      // Strobe output enable
	output reg [ADDR_W-1:0] o_mem_addr,  // Word address to store
	output reg o_mem_reg,                // Access targets register space
	output reg o_row_req,                // Row and upper column known
	output reg o_mem_rd,                 // Read request pulse
	output reg o_mem_wr,                 // Write request pulse
	output reg [15:0] o_mem_wdata,       // Write word, first byte high
	output reg [1:0] o_mem_be,           // Byte enables, bit 1 first byte
	output reg o_active                  // Transaction in progress
);

	// --------------------------------------------------------------
	// Pin synchronisation and edge detection
	// --------------------------------------------------------------
	wire [10:0] sync_q;
	wire cs_s;
	wire ck_s;
	wire rw_data_strobe_s;
	wire [7:0] dq_s;
	reg ck_d;
	wire ck_rise;
	wire ck_fall;
	wire ck_edge;

	dpr_sync #(
		.W(11),
		.INIT(`DPR_SYNC_INIT)
	) u_sync (
		.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n),
		.i_d({i_cs_n, i_ck, i_rw_data_strobe, i_dq}),
		.o_q(sync_q)
	);

	assign cs_s = sync_q[10];
	assign ck_s = sync_q[9];
	assign rw_data_strobe_s = sync_q[8];
	assign dq_s = sync_q[7:0];
	// Apart from select, only host clock edges move the machine, so a stopped clock is harmless
	assign ck_rise = ck_s & ~ck_d;
	assign ck_fall = ~ck_s & ck_d;
	assign ck_edge = ck_rise | ck_fall;

	// --------------------------------------------------------------
	// Transaction state
	// --------------------------------------------------------------
	reg [2:0] state;
	reg [2:0] edge_cnt;
	reg [47:0] ca;
	reg extra_lat;
	reg [7:0] lat_left;
	reg is_read;
	reg linear;
	reg mask_en;
	reg [15:0] rd_word;
	reg rd_pend;
	reg [7:0] wr_hi;
	reg be_hi;
	reg adv;

	wire [47:0] ca_next;
	wire [31:0] addr_full;
	wire [31:0] row_full;
	wire [ADDR_W-1:0] addr_inc;
	wire [ADDR_W-1:0] addr_next;
	wire [7:0] lat_base;
	reg [7:0] lat_total;
	wire lat_none;
	wire byte_keep;

	assign ca_next = {ca[39:0], dq_s};
	// Word address: row and upper column, then the low column bits
	assign addr_full = {ca_next[`DPR_CA_ROW_MSB:`DPR_CA_ROW_LSB],
		ca_next[`DPR_CA_COL_MSB:`DPR_CA_COL_LSB]};
	// After four edges the row bits sit in ca_next[28:0]
	assign row_full = {ca_next[28:0], 3'h0};
	assign addr_inc = o_mem_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
	// Linear rolls over the top of the array; wrapped stays in its window
	assign addr_next = linear ? addr_inc :
		((o_mem_addr & ~i_wrap_mask) | (addr_inc & i_wrap_mask));
	assign lat_base = {{(8-LAT_W){1'b0}}, i_latency};
	// Latency in bus edges: two per clock, four per clock when doubled
	always @* begin
		lat_total = lat_base << `DPR_LAT_EDGES_STD;
		if (extra_lat) begin
			lat_total = lat_base << `DPR_LAT_EDGES_EXT;
		end
	end
	assign lat_none = (i_latency == {LAT_W{1'b0}});
	// Strobe high masks a byte, only when masking is active
	assign byte_keep = ~(mask_en & rw_data_strobe_s);

	// --------------------------------------------------------------
	// Read data return
	// --------------------------------------------------------------
	always @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rd_pend <= 1'b0;
			rd_word <= 16'h0000;
		end else begin
			rd_pend <= o_mem_rd;
			if (rd_pend) begin
				rd_word <= i_mem_rdata;
			end
		end
	end

	// --------------------------------------------------------------
	// Main transaction machine
	// --------------------------------------------------------------
	always @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ck_d <= 1'b0;
			state <= `DPR_ST_IDLE;
			edge_cnt <= 3'h0;
			ca <= 48'h000000000000;
			extra_lat <= 1'b0;
			lat_left <= 8'h00;
			is_read <= 1'b0;
			linear <= 1'b0;
			mask_en <= 1'b0;
			wr_hi <= 8'h00;
			be_hi <= 1'b0;
			adv <= 1'b0;
			o_dq <= 8'h00;
			o_dq_oe <= 1'b0;
			o_rw_data_strobe <= 1'b0;
			o_rw_data_strobe_oe <= 1'b0;
			o_mem_addr <= {ADDR_W{1'b0}};
			o_mem_reg <= 1'b0;
			o_row_req <= 1'b0;
			o_mem_rd <= 1'b0;
			o_mem_wr <= 1'b0;
			o_mem_wdata <= 16'h0000;
			o_mem_be <= 2'h0;
			o_active <= 1'b0;
		end else begin
			ck_d <= ck_s;
			o_row_req <= 1'b0;
			o_mem_rd <= 1'b0;
			o_mem_wr <= 1'b0;
			// Step the address one cycle after a write so it holds under the pulse
			if (adv) begin
				o_mem_addr <= addr_next;
				adv <= 1'b0;
			end
			if (cs_s) begin
				// Select high ends everything and releases the bus
				state <= `DPR_ST_IDLE;
				o_dq_oe <= 1'b0;
				o_rw_data_strobe_oe <= 1'b0;
				o_rw_data_strobe <= 1'b0;
				o_active <= 1'b0;
				adv <= 1'b0;
				// Clear leftover data and mask so no later command inherits them
				o_dq <= 8'h00;
				mask_en <= 1'b0;
			end else begin
				case (state)
				`DPR_ST_IDLE: begin
					// Host starts with the clock idle, so no edge is pending here
					state <= `DPR_ST_CA;
					edge_cnt <= 3'h0;
					extra_lat <= i_refresh_busy;
					o_rw_data_strobe <= i_refresh_busy;
					o_rw_data_strobe_oe <= 1'b1;
					o_active <= 1'b1;
				end
				`DPR_ST_CA: begin
					if (ck_edge) begin
						ca <= ca_next;
						edge_cnt <= edge_cnt + 3'h1;
						if (edge_cnt == `DPR_ROW_LAST_EDGE) begin
							o_mem_addr <= row_full[ADDR_W-1:0];
							o_row_req <= 1'b1;
						end
						if (edge_cnt == `DPR_CA_LAST_EDGE) begin
							is_read <= ca_next[`DPR_CA_READ_BIT];
							o_mem_reg <= ca_next[`DPR_CA_SPACE_BIT];
							linear <= ca_next[`DPR_CA_BURST_BIT];
							o_mem_addr <= addr_full[ADDR_W-1:0];
							lat_left <= lat_total;
							if (ca_next[`DPR_CA_READ_BIT]) begin
								// Fetch first word during latency; hold strobe low
								o_mem_rd <= 1'b1;
								o_rw_data_strobe <= 1'b0;
								if (lat_none) begin
									state <= `DPR_ST_RDATA;
									o_dq_oe <= 1'b1;
								end else begin
									state <= `DPR_ST_LAT;
								end
							end else if (ca_next[`DPR_CA_SPACE_BIT]) begin
								// Zero-latency register write: no mask, strobe released
								o_rw_data_strobe_oe <= 1'b0;
								mask_en <= 1'b0;
								state <= `DPR_ST_WDATA;
							end else begin
								// Host takes the strobe as a mask only when latency leaves room
								o_rw_data_strobe_oe <= 1'b0;
								if (lat_none) begin
									mask_en <= 1'b0;
									state <= `DPR_ST_WDATA;
								end else begin
									mask_en <= 1'b1;
									state <= `DPR_ST_LAT;
								end
							end
						end
					end
				end
				`DPR_ST_LAT: begin
					if (ck_edge) begin
						lat_left <= lat_left - 8'h01;
						if (lat_left == 8'h01) begin
							state <= is_read ? `DPR_ST_RDATA : `DPR_ST_WDATA;
							o_dq_oe <= is_read;
						end
					end
				end
				`DPR_ST_RDATA: begin
					// Strobe and data change together, first byte high half
					if (ck_rise) begin
						o_dq <= rd_word[15:8];
						o_rw_data_strobe <= 1'b1;
					end else if (ck_fall) begin
						o_dq <= rd_word[7:0];
						o_rw_data_strobe <= 1'b0;
						o_mem_addr <= addr_next;
						o_mem_rd <= 1'b1;
					end
				end
				`DPR_ST_WDATA: begin
					if (ck_rise) begin
						wr_hi <= dq_s;
						be_hi <= byte_keep;
					end else if (ck_fall) begin
						o_mem_wdata <= {wr_hi, dq_s};
						o_mem_be <= {be_hi, byte_keep};
						o_mem_wr <= 1'b1;
						adv <= 1'b1;
					end
				end
				default: begin
					state <= `DPR_ST_IDLE;
				end
				endcase
			end
		end
	end

endmodule

// [verification/dpr_slave_sva.sv]
// Checker for the DDR bus slave ports.
// Assumes one reference clock domain; bound to dpr_slave.
`timescale 1ns/1ns

module dpr_slave_chk (
	input wire i_ref_clk, // Clock
	input wire i_reset_n, // Reset
	input wire i_cs_n, // Select
	input wire i_refresh_busy, // Extra latency
	input wire [7:0] o_dq, // Data out
	input wire o_dq_oe, // Data enable
	input wire o_rw_data_strobe, // Strobe
	input wire o_rw_data_strobe_oe, // Strobe enable
	input wire o_row_req, // Row known
	input wire o_mem_rd, // Read pulse
	input wire o_mem_wr, // Write pulse
	input wire o_active // In transaction
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);

	sel_idle_a: assert property (i_cs_n [*6] |-> !o_dq_oe && !o_rw_data_strobe_oe && !o_active)
		else $error("Outputs active while deselected");
	lat_flag_a: assert property ($rose(o_rw_data_strobe_oe) |-> o_rw_data_strobe == i_refresh_busy)
		else $error("Latency flag wrong");
	rd_strobe_a: assert property (o_dq_oe |-> o_rw_data_strobe_oe)
		else $error("Data driven without strobe");
	edge_align_a: assert property (o_dq_oe && $past(o_dq_oe) && $changed(o_dq) |-> $changed(o_rw_data_strobe))
		else $error("Data change off strobe edge");
	wr_release_a: assert property (o_mem_wr |-> !o_dq_oe && !o_rw_data_strobe_oe)
		else $error("Device drives bus in write");
	row_first_a: assert property (o_row_req |=> !o_mem_rd [*6])
		else $error("Read too soon after row");
	sel_start_a: assert property ($rose(o_active) |-> !$past(i_cs_n, 2))
		else $error("Start without select");
	rd_space_a: assert property (o_mem_rd |=> !o_mem_rd [*7])
		else $error("Reads closer than one word");

	cover property ($rose(o_dq_oe));
	cover property (o_mem_wr);
	cover property ($rose(o_rw_data_strobe_oe) && o_rw_data_strobe);
endmodule

bind dpr_slave dpr_slave_chk u_chk (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
	.i_cs_n(i_cs_n), .i_refresh_busy(i_refresh_busy), .o_dq(o_dq), .o_dq_oe(o_dq_oe),
	.o_rw_data_strobe(o_rw_data_strobe), .o_rw_data_strobe_oe(o_rw_data_strobe_oe),
	.o_row_req(o_row_req), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_active(o_active));

// [verification/dpr_host.sv]
// Host model: drives select, bus clock, data and write mask.
// Assumes the bench clock; bus half period is 4 clocks.
`timescale 1ns/1ns

module dpr_host (
	input wire i_ref_clk, // Clock
	output logic o_cs_n = 1'b1, // Select
	output logic o_ck = 1'b0, // Bus clock
	output logic [7:0] o_dq = 8'h00, // Data
	output logic o_strobe = 1'b0, // Write mask
	output logic o_strobe_oe = 1'b0 // Mask driven
);
	task automatic tick(input logic [7:0] d, input logic s);
		o_dq <= d;
		o_strobe <= s;
		repeat (2) @(posedge i_ref_clk);
		o_ck <= ~o_ck;
		repeat (2) @(posedge i_ref_clk);
	endtask

	task automatic idle();
		o_ck <= 1'b0;
		repeat (8) @(posedge i_ref_clk);
		o_cs_n <= 1'b1;
		o_strobe_oe <= 1'b0;
		repeat (8) @(posedge i_ref_clk);
	endtask

	task automatic xfer(input logic [47:0] ca, input int nl, input int nw, input bit wr,
		input bit msk);
		int i;
		o_cs_n <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
		for (i = 0; i < 6; i++) begin
			tick(ca[47 - 8 * i -: 8], 1'b0);
		end
		if (wr && nl > 0) begin
			// Let the device release the strobe before taking it over
			repeat (2) @(posedge i_ref_clk);
			o_strobe_oe <= 1'b1;
		end
		for (i = 0; i < nl; i++) begin
			tick(~o_dq, 1'b0);
		end
		for (i = 0; i < 2 * nw; i++) begin
			tick(wr ? 8'h30 + i[7:0] : ~o_dq, msk && (i == 0 || i == 2 * nw - 1));
		end
		idle();
	endtask
endmodule

// [verification/dpr_slave_test.sv]
// Bench for the DDR bus slave: reads, writes, reset.
// Assumes dpr_host on the bus and a store answering one clock late.
`timescale 1ns/1ns

module dpr_slave_test;
	typedef struct {bit rd; bit rg; bit lin; bit busy; bit msk; logic [3:0] lat;
		logic [22:0] a; int n;} dpr_row_t;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic busy = 1'b0;
	logic ps = 1'b0;
	logic [3:0] lat = 4'h0;
	logic [15:0] rdata = 16'h0000;
	logic [22:0] a;
	logic [15:0] w;
	logic [1:0] eb;
	wire cs_n, ck, h_stb, h_oe, d_stb, d_oe, dq_oe, mem_rd, mem_wr, active, stb, mreg;
	wire [7:0] h_dq, d_dq;
	wire [22:0] maddr;
	wire [15:0] wdata;
	wire [1:0] be;
	int failures = 0;
	int n_tests = 0;
	int k;
	int r;
	logic [7:0] rq[$];
	logic [40:0] wq[$];
	dpr_row_t rows[6] = '{'{1, 0, 0, 0, 0, 4'h2, 23'h000006, 4},
		'{1, 0, 1, 1, 0, 4'h1, 23'h7ffffe, 4}, '{1, 1, 1, 0, 0, 4'h0, 23'h000002, 2},
		'{0, 0, 1, 1, 1, 4'h1, 23'h000100, 3}, '{0, 1, 1, 0, 0, 4'h3, 23'h000005, 2},
		'{0, 0, 0, 0, 1, 4'h0, 23'h000003, 2}};

	always #25 ref_clk = ~ref_clk;
	// Undriven strobe line floats high, which would mask if honoured
	assign stb = d_oe ? d_stb : h_oe ? h_stb : 1'b1;

	dpr_slave DUT (.i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_cs_n(cs_n), .i_ck(ck),
		.i_dq(h_dq), .i_rw_data_strobe(stb), .i_latency(lat), .i_refresh_busy(busy),
		.i_wrap_mask(23'h000007), .i_mem_rdata(rdata), .o_dq(d_dq), .o_dq_oe(dq_oe),
		.o_rw_data_strobe(d_stb), .o_rw_data_strobe_oe(d_oe), .o_mem_addr(maddr),
		.o_mem_reg(mreg), .o_row_req(), .o_mem_rd(mem_rd), .o_mem_wr(mem_wr),
		.o_mem_wdata(wdata), .o_mem_be(be), .o_active(active));
	dpr_host host (.i_ref_clk(ref_clk), .o_cs_n(cs_n), .o_ck(ck), .o_dq(h_dq),
		.o_strobe(h_stb), .o_strobe_oe(h_oe));

	always @(posedge ref_clk) begin
		if (mem_rd) rdata <= {maddr[7:0], maddr[22:15]};
		if (dq_oe && d_oe && d_stb !== ps) rq.push_back(d_dq);
		if (mem_wr) wq.push_back({maddr, be, wdata});
		ps <= d_stb;
	end

	task check(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic run(input dpr_row_t t);
		int nl;
		lat <= t.lat;
		busy <= t.busy;
		@(posedge ref_clk);
		rq.delete();
		wq.delete();
		nl = (t.rd || !t.rg) ? 2 * t.lat * (t.busy ? 2 : 1) : 0;
		host.xfer({t.rd, t.rg, t.lin, 9'h000, t.a[22:3], 13'h0000, t.a[2:0]}, nl, t.n, !t.rd,
			t.msk);
		a = t.a;
		check(t.rd ? rq.size() : wq.size(), t.rd ? 2 * t.n : t.n);
		check(mreg, t.rg);
		for (k = 0; k < t.n; k++) begin
			w = {a[7:0], a[22:15]};
			eb = {!(t.msk && nl > 0 && k == 0), !(t.msk && nl > 0 && k == t.n - 1)};
			if (t.rd) begin
				check(rq[2 * k], w[15:8]);
				check(rq[2 * k + 1], w[7:0]);
			end else begin
				check(wq[k], {a, eb, 8'h30 + 8'(2 * k), 8'h31 + 8'(2 * k)});
			end
			a = t.lin ? a + 23'h1 : {a[22:3], a[2:0] + 3'h1};
		end
		$display("Row done: rd %0d reg %0d lin %0d", t.rd, t.rg, t.lin);
	endtask

	task results();
		$display("Comparisons %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge ref_clk);
		check({dq_oe, d_oe, active, mem_rd, mem_wr}, 5'h00);
		reset_n <= 1'b1;
		for (r = 0; r < 6; r++) begin
			run(rows[r]);
		end
		// Reset lands in the middle of a read
		fork
			host.xfer(48'h8000_0000_0000, 4, 4, 1'b0, 1'b0);
		join_none
		repeat (30) @(posedge ref_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check({dq_oe, d_oe, active, mem_rd, mem_wr}, 5'h00);
		disable fork;
		host.idle();
		reset_n <= 1'b1;
		$display("Reset test done");
		run(rows[0]);
		results();
	end
endmodule
